// ---- logic/gpt_unit.v ----
// dual-group timer/counter unit with an APB register slave.
// assumes an APB3 master on clk_i and asynchronous port pins.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "gpt_map.vh"

module gpt_unit (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // first group pins
  input wire core_count_i,
  input wire core_dir_i,
  input wire aux_low_in_i,
  input wire aux_low_dir_i,
  input wire aux_high_in_i,
  input wire aux_high_dir_i,
  // second group pins
  input wire fast_core_in_i,
  input wire fast_core_dir_i,
  input wire fast_aux_in_i,
  input wire capture_in_i,
  // outputs
  output reg core_toggle_o,
  output reg fast_toggle_o,
  output reg compare_clk_o,
  output reg [`NTMR-1:0] tmr_event_o
);

  // edge select hit: bit 0 rising, bit 1 falling
  function edge_hit;
    input r;
    input f;
    input [1:0] sel;
    begin
      edge_hit = (r & sel[0]) | (f & sel[1]);
    end
  endfunction

  // event step for the modes that do not use the prescaler
  function step_evt;
    input [`CTRL_W-1:0] c;
    input in_r;
    input in_f;
    input tl_r;
    input tl_f;
    input quad;
    reg [2:0] m;
    begin
      m = c[`F_MODE_HI:`F_MODE_LO];
      if (m == `M_COUNT) begin
        step_evt = edge_hit(in_r, in_f, c[`F_ESEL_HI:`F_ESEL_LO]);
      end else if (m == `M_INCR) begin
        step_evt = quad;
      end else if (m == `M_CONCAT) begin
        step_evt = edge_hit(tl_r, tl_f, c[`F_ESEL_HI:`F_ESEL_LO]);
      end else begin
        step_evt = 1'b0;
      end
    end
  endfunction

  // count direction, 1 means down
  function dir_down;
    input [`CTRL_W-1:0] c;
    input lvl;
    input q_up;
    begin
      if (c[`F_MODE_HI:`F_MODE_LO] == `M_INCR) begin
        dir_down = ~q_up ^ c[`F_DIR];
      end else if (c[`F_DIREXT]) begin
        dir_down = lvl ^ c[`F_DIR];
      end else begin
        dir_down = c[`F_DIR];
      end
    end
  endfunction

  // quadrature direction: A leads B means up
  function quad_up;
    input a;
    input b;
    input a_edge;
    begin
      quad_up = a_edge ? (a != b) : (a == b);
    end
  endfunction

  // prescaler modes, also giving the run qualifier
  function uses_presc;
    input [`CTRL_W-1:0] c;
    begin
      uses_presc = (c[`F_MODE_HI:`F_MODE_LO] == `M_TIMER) |
                   (c[`F_MODE_HI:`F_MODE_LO] == `M_GATED);
    end
  endfunction

  function runs;
    input [`CTRL_W-1:0] c;
    begin
      runs = c[`F_RUN] & (c[`F_MODE_HI:`F_MODE_LO] != `M_RELOAD) &
             (c[`F_MODE_HI:`F_MODE_LO] != `M_CAPT);
    end
  endfunction

  function gate_ok;
    input [`CTRL_W-1:0] c;
    input lvl;
    begin
      gate_ok = (c[`F_MODE_HI:`F_MODE_LO] != `M_GATED) |
                (lvl ^ c[`F_GATELO]);
    end
  endfunction

  reg [`NPIN-1:0] sync1_q, sync2_q, prev_q;
  reg [`CTRL_W-1:0] c_core_q, c_low_q, c_high_q, c_fcore_q, c_faux_q;
  reg [`TW-1:0] capture_reload_reg_q;
  reg [`NTMR-1:0] sticky_q;
  reg core_tl_q, fast_tl_q;
  reg [31:0] rd_data;
  reg rd_err;
  wire [`NPIN-1:0] pin_raw, rise, fall;
  wire [`TW-1:0] v_core, v_low, v_high, v_fcore, v_faux;
  wire [`NTMR-1:0] ovf, unf, wrap;
  wire acc, wr, wr_ok;

  assign pin_raw = {capture_in_i, fast_aux_in_i, fast_core_dir_i,
                    fast_core_in_i, aux_high_dir_i, aux_high_in_i,
                    aux_low_dir_i, aux_low_in_i, core_dir_i, core_count_i};

  // two-flop synchronisers; edges only look at the second stage
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= {`NPIN{1'b0}};
      sync2_q <= {`NPIN{1'b0}};
      prev_q <= {`NPIN{1'b0}};
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // pulses shorter than one clock may vanish here
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign wrap = ovf | unf;

  // apb: one wait state, write lands on the edge that samples pready
  assign acc = psel_i & penable_i;
  assign wr = acc & pready_o & pwrite_i;
  assign wr_ok = wr & ~rd_err;

  // toggle latch transitions, seen one cycle ahead of the flip
  wire core_tl_r = wrap[`I_CORE] & ~core_tl_q;
  wire core_tl_f = wrap[`I_CORE] & core_tl_q;
  wire fast_tl_r = wrap[`I_FCORE] & ~fast_tl_q;
  wire fast_tl_f = wrap[`I_FCORE] & fast_tl_q;

  // encoder edges for each first-group timer
  wire a_c = rise[`P_CORE_IN] | fall[`P_CORE_IN];
  wire b_c = rise[`P_CORE_DIR] | fall[`P_CORE_DIR];
  wire a_l = rise[`P_LOW_IN] | fall[`P_LOW_IN];
  wire b_l = rise[`P_LOW_DIR] | fall[`P_LOW_DIR];
  wire a_h = rise[`P_HIGH_IN] | fall[`P_HIGH_IN];
  wire b_h = rise[`P_HIGH_DIR] | fall[`P_HIGH_DIR];
  wire up_c = quad_up(sync2_q[`P_CORE_IN], sync2_q[`P_CORE_DIR], a_c);
  wire up_l = quad_up(sync2_q[`P_LOW_IN], sync2_q[`P_LOW_DIR], a_l);
  wire up_h = quad_up(sync2_q[`P_HIGH_IN], sync2_q[`P_HIGH_DIR], a_h);

  // write strobes per value register and the status word
  wire w_core = wr_ok & (paddr_i == `OFS_CORE);
  wire w_low = wr_ok & (paddr_i == `OFS_LOW);
  wire w_high = wr_ok & (paddr_i == `OFS_HIGH);
  wire w_fcore = wr_ok & (paddr_i == `OFS_FCORE);
  wire w_faux = wr_ok & (paddr_i == `OFS_FAUX);
  wire w_capture_reload_reg = wr_ok & (paddr_i == `OFS_CAPTURE_RELOAD_REG);
  wire w_status = wr_ok & (paddr_i == `OFS_STATUS);

  // capture and reload triggers of the auxiliary timers
  wire cap_low = (c_low_q[`F_MODE_HI:`F_MODE_LO] == `M_CAPT) &
    edge_hit(rise[`P_LOW_IN], fall[`P_LOW_IN],
             c_low_q[`F_ESEL_HI:`F_ESEL_LO]);
  wire cap_high = (c_high_q[`F_MODE_HI:`F_MODE_LO] == `M_CAPT) &
    edge_hit(rise[`P_HIGH_IN], fall[`P_HIGH_IN],
             c_high_q[`F_ESEL_HI:`F_ESEL_LO]);
  wire rel_low = (c_low_q[`F_MODE_HI:`F_MODE_LO] == `M_RELOAD) &
    (edge_hit(rise[`P_LOW_IN], fall[`P_LOW_IN],
              c_low_q[`F_ESEL_HI:`F_ESEL_LO]) |
     (c_low_q[`F_TLREL] &
      (c_low_q[`F_TLSEL] ? core_tl_f : core_tl_r)));
  wire rel_high = (c_high_q[`F_MODE_HI:`F_MODE_LO] == `M_RELOAD) &
    (edge_hit(rise[`P_HIGH_IN], fall[`P_HIGH_IN],
              c_high_q[`F_ESEL_HI:`F_ESEL_LO]) |
     (c_high_q[`F_TLREL] &
      (c_high_q[`F_TLSEL] ? core_tl_f : core_tl_r)));

  // capture/reload register trigger from the selected sources
  wire [1:0] csrc = c_faux_q[`F_CSRC_HI:`F_CSRC_LO];
  wire [1:0] fesel = c_faux_q[`F_ESEL_HI:`F_ESEL_LO];
  wire cap_pin = edge_hit(rise[`P_CAPTURE_INPUT_PIN], fall[`P_CAPTURE_INPUT_PIN], fesel);
  wire cap_cin = edge_hit(rise[`P_CORE_IN], fall[`P_CORE_IN], fesel);
  wire cap_cdir = edge_hit(rise[`P_CORE_DIR], fall[`P_CORE_DIR], fesel);
  wire cap_fast = (csrc == `CS_CAPTURE_INPUT_PIN) ? cap_pin :
                  (csrc == `CS_CORE_IN) ? cap_cin :
                  (csrc == `CS_CORE_DIR) ? cap_cdir :
                  (cap_cin | cap_cdir);
  wire rel_fcore = c_fcore_q[`F_CAPTURE_RELOAD_REG] & wrap[`I_FCORE];

  // reload into core: software first, then low, then high; with both
  // set to opposite latch edges they alternate and form the pwm
  wire ld_core = w_core | rel_low | rel_high;
  wire [`TW-1:0] lv_core = w_core ? pwdata_i[`TW-1:0] :
                           rel_low ? v_low : v_high;

  // core timer; every cell holds one 16-bit value
  tmr_cell #(.BASE_LOG(`BASE_LOG_G1)) u_core (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(runs(c_core_q)),
    .use_presc_i(uses_presc(c_core_q)),
    .gate_i(gate_ok(c_core_q, sync2_q[`P_CORE_IN])),
    .evt_i(step_evt(c_core_q, rise[`P_CORE_IN], fall[`P_CORE_IN],
                    1'b0, 1'b0, a_c | b_c)),
    .down_i(dir_down(c_core_q, sync2_q[`P_CORE_DIR], up_c)),
    .presc_i(c_core_q[`F_PRE_HI:`F_PRE_LO]),
    .ld_i(ld_core),
    .ld_val_i(lv_core),
    .value_o(v_core),
    .ovf_o(ovf[`I_CORE]),
    .unf_o(unf[`I_CORE])
  );

  // low auxiliary timer; stops while capturing or reloading
  tmr_cell #(.BASE_LOG(`BASE_LOG_G1)) u_low (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(runs(c_low_q)),
    .use_presc_i(uses_presc(c_low_q)),
    .gate_i(gate_ok(c_low_q, sync2_q[`P_LOW_IN])),
    .evt_i(step_evt(c_low_q, rise[`P_LOW_IN], fall[`P_LOW_IN],
                    core_tl_r, core_tl_f, a_l | b_l)),
    .down_i(dir_down(c_low_q, sync2_q[`P_LOW_DIR], up_l)),
    .presc_i(c_low_q[`F_PRE_HI:`F_PRE_LO]),
    .ld_i(w_low | cap_low),
    .ld_val_i(w_low ? pwdata_i[`TW-1:0] : v_core),
    .value_o(v_low),
    .ovf_o(ovf[`I_LOW]),
    .unf_o(unf[`I_LOW])
  );

  // high auxiliary timer, same structure as the low one
  tmr_cell #(.BASE_LOG(`BASE_LOG_G1)) u_high (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(runs(c_high_q)),
    .use_presc_i(uses_presc(c_high_q)),
    .gate_i(gate_ok(c_high_q, sync2_q[`P_HIGH_IN])),
    .evt_i(step_evt(c_high_q, rise[`P_HIGH_IN], fall[`P_HIGH_IN],
                    core_tl_r, core_tl_f, a_h | b_h)),
    .down_i(dir_down(c_high_q, sync2_q[`P_HIGH_DIR], up_h)),
    .presc_i(c_high_q[`F_PRE_HI:`F_PRE_LO]),
    .ld_i(w_high | cap_high),
    .ld_val_i(w_high ? pwdata_i[`TW-1:0] : v_core),
    .value_o(v_high),
    .ovf_o(ovf[`I_HIGH]),
    .unf_o(unf[`I_HIGH])
  );

  // fast core timer; prescaled or external clock only
  tmr_cell #(.BASE_LOG(`BASE_LOG_G2)) u_fcore (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(runs(c_fcore_q)),
    .use_presc_i(uses_presc(c_fcore_q)),
    .gate_i(gate_ok(c_fcore_q, sync2_q[`P_FCORE_IN])),
    .evt_i(step_evt(c_fcore_q, rise[`P_FCORE_IN], fall[`P_FCORE_IN],
                    1'b0, 1'b0, 1'b0)),
    .down_i(dir_down(c_fcore_q, sync2_q[`P_FCORE_DIR], 1'b1)),
    .presc_i(c_fcore_q[`F_PRE_HI:`F_PRE_LO]),
    .ld_i(w_fcore | rel_fcore),
    .ld_val_i(w_fcore ? pwdata_i[`TW-1:0] : capture_reload_reg_q),
    .value_o(v_fcore),
    .ovf_o(ovf[`I_FCORE]),
    .unf_o(unf[`I_FCORE])
  );

  // fast aux timer; a capture with clear set zeroes it
  tmr_cell #(.BASE_LOG(`BASE_LOG_G2)) u_faux (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(runs(c_faux_q)),
    .use_presc_i(uses_presc(c_faux_q)),
    .gate_i(gate_ok(c_faux_q, sync2_q[`P_FAUX_IN])),
    .evt_i(step_evt(c_faux_q, rise[`P_FAUX_IN], fall[`P_FAUX_IN],
                    fast_tl_r, fast_tl_f, 1'b0)),
    .down_i(c_faux_q[`F_DIR]),
    .presc_i(c_faux_q[`F_PRE_HI:`F_PRE_LO]),
    .ld_i(w_faux | (cap_fast & c_faux_q[`F_CLR])),
    .ld_val_i(w_faux ? pwdata_i[`TW-1:0] : `ZERO16),
    .value_o(v_faux),
    .ovf_o(ovf[`I_FAUX]),
    .unf_o(unf[`I_FAUX])
  );

  // control words, capture register and toggle latches
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_core_q <= `CTRL_RST;
      c_low_q <= `CTRL_RST;
      c_high_q <= `CTRL_RST;
      c_fcore_q <= `CTRL_RST;
      c_faux_q <= `CTRL_RST;
      capture_reload_reg_q <= `ZERO16;
      core_tl_q <= 1'b0;
      fast_tl_q <= 1'b0;
    end else begin
      if (wr_ok && paddr_i == `OFS_C_CORE) begin
        c_core_q <= pwdata_i[`CTRL_W-1:0];
      end
      if (wr_ok && paddr_i == `OFS_C_LOW) begin
        c_low_q <= pwdata_i[`CTRL_W-1:0];
      end
      if (wr_ok && paddr_i == `OFS_C_HIGH) begin
        c_high_q <= pwdata_i[`CTRL_W-1:0];
      end
      if (wr_ok && paddr_i == `OFS_C_FCORE) begin
        c_fcore_q <= pwdata_i[`CTRL_W-1:0];
      end
      if (wr_ok && paddr_i == `OFS_C_FAUX) begin
        c_faux_q <= pwdata_i[`CTRL_W-1:0];
      end
      // a hardware capture beats a software write in the same cycle
      if (cap_fast) begin
        capture_reload_reg_q <= v_faux;
      end else if (w_capture_reload_reg) begin
        capture_reload_reg_q <= pwdata_i[`TW-1:0];
      end
      core_tl_q <= core_tl_q ^ wrap[`I_CORE];
      fast_tl_q <= fast_tl_q ^ wrap[`I_FCORE];
    end
  end

  // sticky wrap flags, write one to clear; a new wrap wins
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sticky_q <= {`NTMR{1'b0}};
    end else begin
      sticky_q <= wrap |
        (sticky_q & ~(w_status ? pwdata_i[`NTMR-1:0] : {`NTMR{1'b0}}));
    end
  end

  // read decode; unmapped addresses answer zero with an error
  always @* begin
    rd_data = `ZERO32;
    rd_err = 1'b0;
    if (paddr_i == `OFS_CORE) begin
      rd_data[`TW-1:0] = v_core;
    end else if (paddr_i == `OFS_LOW) begin
      rd_data[`TW-1:0] = v_low;
    end else if (paddr_i == `OFS_HIGH) begin
      rd_data[`TW-1:0] = v_high;
    end else if (paddr_i == `OFS_FCORE) begin
      rd_data[`TW-1:0] = v_fcore;
    end else if (paddr_i == `OFS_FAUX) begin
      rd_data[`TW-1:0] = v_faux;
    end else if (paddr_i == `OFS_CAPTURE_RELOAD_REG) begin
      rd_data[`TW-1:0] = capture_reload_reg_q;
    end else if (paddr_i == `OFS_C_CORE) begin
      rd_data[`CTRL_W-1:0] = c_core_q;
    end else if (paddr_i == `OFS_C_LOW) begin
      rd_data[`CTRL_W-1:0] = c_low_q;
    end else if (paddr_i == `OFS_C_HIGH) begin
      rd_data[`CTRL_W-1:0] = c_high_q;
    end else if (paddr_i == `OFS_C_FCORE) begin
      rd_data[`CTRL_W-1:0] = c_fcore_q;
    end else if (paddr_i == `OFS_C_FAUX) begin
      rd_data[`CTRL_W-1:0] = c_faux_q;
    end else if (paddr_i == `OFS_STATUS) begin
      rd_data[`NTMR-1:0] = sticky_q;
      rd_data[`ST_CORE_TL] = core_tl_q;
      rd_data[`ST_FAST_TL] = fast_tl_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // apb answer: pready rises one cycle into the access phase
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= `ZERO32;
    end else begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & rd_err;
      if (acc && !pready_o && !pwrite_i) begin
        prdata_o <= rd_data;
      end
    end
  end

  // registered pin and event outputs
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_toggle_o <= 1'b0;
      fast_toggle_o <= 1'b0;
      compare_clk_o <= 1'b0;
      tmr_event_o <= {`NTMR{1'b0}};
    end else begin
      core_toggle_o <= core_tl_q & c_core_q[`F_TOUT];
      fast_toggle_o <= fast_tl_q & c_fcore_q[`F_TOUT];
      compare_clk_o <= wrap[`I_FCORE];
      tmr_event_o <= wrap;
    end
  end

endmodule // gpt_unit

// ---- logic/gpt_map.vh ----
// constants of the dual-group timer/counter: register offsets, control
// fields, mode codes, pin indices and prescaler sizing.
// assumes inclusion by bare name from every design file of the block.
`ifndef GPT_MAP_VH
`define GPT_MAP_VH

// widths
`define TW 16
`define CTRL_W 19
`define PRE_W 10
`define NPIN 10
`define NTMR 5

// register byte offsets, one aligned word each
`define OFS_CORE 8'h00
`define OFS_LOW 8'h04
`define OFS_HIGH 8'h08
`define OFS_FCORE 8'h0C
`define OFS_FAUX 8'h10
`define OFS_CAPTURE_RELOAD_REG 8'h14
`define OFS_C_CORE 8'h18
`define OFS_C_LOW 8'h1C
`define OFS_C_HIGH 8'h20
`define OFS_C_FCORE 8'h24
`define OFS_C_FAUX 8'h28
`define OFS_STATUS 8'h2C

// control word fields, same layout for all five timers
`define F_MODE_LO 0
`define F_MODE_HI 2
`define F_RUN 3
`define F_DIR 4
`define F_DIREXT 5
`define F_PRE_LO 6
`define F_PRE_HI 8
`define F_ESEL_LO 9
`define F_ESEL_HI 10
`define F_TLREL 11
`define F_TLSEL 12
`define F_TOUT 13
`define F_CLR 14
`define F_CAPTURE_RELOAD_REG 15
`define F_CSRC_LO 16
`define F_CSRC_HI 17
`define F_GATELO 18
`define CTRL_RST 19'h0_0000

// operating modes
`define M_TIMER 3'h0
`define M_GATED 3'h1
`define M_COUNT 3'h2
`define M_INCR 3'h3
`define M_RELOAD 3'h4
`define M_CAPT 3'h5
`define M_CONCAT 3'h6

// capture source select of the capture/reload register
`define CS_CAPTURE_INPUT_PIN 2'h0
`define CS_CORE_IN 2'h1
`define CS_CORE_DIR 2'h2

// status word: sticky wrap flags at bits 4..0, latch states above
`define ST_CORE_TL 5
`define ST_FAST_TL 6

// pin indices in the synchroniser vector
`define P_CORE_IN 0
`define P_CORE_DIR 1
`define P_LOW_IN 2
`define P_LOW_DIR 3
`define P_HIGH_IN 4
`define P_HIGH_DIR 5
`define P_FCORE_IN 6
`define P_FCORE_DIR 7
`define P_FAUX_IN 8
`define P_CAPTURE_INPUT_PIN 9

// timer indices for event and status bits
`define I_CORE 0
`define I_LOW 1
`define I_HIGH 2
`define I_FCORE 3
`define I_FAUX 4

// finest resolution as log2 of system clock cycles
`define BASE_LOG_G1 2
`define BASE_LOG_G2 1

`define ZERO16 16'h0000
`define ALL1_16 16'hFFFF
`define ZERO32 32'h0000_0000

`endif

// ---- logic/tmr_cell.v ----
// one 16-bit up/down timer with its own prescaler and wrap detection.
// assumes step, gate and direction arrive already synchronised to clk_i.
`timescale 1ns/1ps
`include "gpt_map.vh"

module tmr_cell #(
  parameter BASE_LOG = `BASE_LOG_G1
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // count control
  input wire run_i,
  input wire use_presc_i,
  input wire gate_i,
  input wire evt_i,
  input wire down_i,
  input wire [2:0] presc_i,
  // parallel load
  input wire ld_i,
  input wire [`TW-1:0] ld_val_i,
  // state and wrap pulses
  output reg [`TW-1:0] value_o,
  output reg ovf_o,
  output reg unf_o
);

  reg [`PRE_W-1:0] pre_q;
  wire [`PRE_W-1:0] pre_lim;
  wire tick;
  wire step;

  // divide by 2^(base+presc); base sets the finest resolution
  assign pre_lim = {{(`PRE_W-1){1'b0}}, 1'b1} << (BASE_LOG + presc_i);
  assign tick = (pre_q == pre_lim - {{(`PRE_W-1){1'b0}}, 1'b1});
  assign step = run_i & (use_presc_i ? (tick & gate_i) : evt_i);

  // prescaler runs free while enabled so a gate never shifts its phase
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= {`PRE_W{1'b0}};
    end else if (!run_i || !use_presc_i || tick) begin
      pre_q <= {`PRE_W{1'b0}};
    end else begin
      pre_q <= pre_q + {{(`PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // counter; a load beats a count step in the same cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_o <= `ZERO16;
      ovf_o <= 1'b0;
      unf_o <= 1'b0;
    end else begin
      ovf_o <= 1'b0;
      unf_o <= 1'b0;
      if (ld_i) begin
        value_o <= ld_val_i;
      end else if (step) begin
        if (down_i) begin
          value_o <= value_o - 16'h0001;
          unf_o <= (value_o == `ZERO16);
        end else begin
          value_o <= value_o + 16'h0001;
          ovf_o <= (value_o == `ALL1_16);
        end
      end
    end
  end

endmodule // tmr_cell

// ---- dv/gpt_unit_assertions.sv ----
// checker of the timer unit: apb answer timing and toggle pin relations.
// assumes it is bound to gpt_unit and sees only that module's ports.
`timescale 1ns/1ps
`include "gpt_map.vh"
module gpt_unit_assertions (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // timer outputs
  input wire core_toggle_o,
  input wire fast_toggle_o,
  input wire [`NTMR-1:0] tmr_event_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // address classes, valid while the master holds its request
  wire rd_now = pready_o && !pwrite_i;
  wire bad_adr = paddr_i > `OFS_STATUS || paddr_i[1:0] != 2'h0;
  wire val_adr = paddr_i <= `OFS_CAPTURE_RELOAD_REG;
  wire ctl_adr = !val_adr && paddr_i < `OFS_STATUS;
  wire wr_core = pwrite_i && paddr_i == `OFS_C_CORE;
  wire wr_fast = pwrite_i && paddr_i == `OFS_C_FCORE;
  // access phase waiting, then the answer
  sequence s_req;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_xfer;
    s_req ##1 pready_o;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> pready_o)
    else $error("answer missing one cycle after access");
  AST_RDY_PULSE: assert property (s_xfer |=> !pready_o)
    else $error("ready held past one cycle");
  AST_RDY_CAUSE: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without an access");
  AST_ERR_MAP: assert property (pready_o |-> pslverr_o == bad_adr)
    else $error("error flag disagrees with address map");
  AST_ERR_RDY: assert property (pslverr_o |-> pready_o)
    else $error("error flag outside an answer");
  AST_ERR_ZERO: assert property (rd_now && bad_adr |-> prdata_o == `ZERO32)
    else $error("unmapped read returned data");
  AST_VAL_W16: assert property (
    rd_now && val_adr |-> prdata_o[31:16] == 16'h0000)
    else $error("timer value wider than 16 bits");
  AST_CTL_W: assert property (rd_now && ctl_adr |-> prdata_o[31:19] == 13'h0000)
    else $error("control word wider than its fields");
  // toggle pins move only on a wrap or on a control write
  // the pin trails its event pulse by one cycle and a control write by two
  AST_CORE_TOG: assert property (
    $changed(core_toggle_o) |->
      $past(tmr_event_o[`I_CORE]) || $past(pready_o && wr_core, 2))
    else $error("core toggle pin moved without cause");
  AST_FAST_TOG: assert property (
    $changed(fast_toggle_o) |->
      $past(tmr_event_o[`I_FCORE]) || $past(pready_o && wr_fast, 2))
    else $error("fast toggle pin moved without cause");
endmodule // gpt_unit_assertions

bind gpt_unit gpt_unit_assertions u_chk (.*);

// ---- dv/sensor_model.sv ----
// pin-side model: encoder, gate and event sources on the timer pins.
// assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`include "gpt_map.vh"
module sensor_model (
  // clock
  input wire logic clk_i,
  // pin levels
  output logic [`NPIN-1:0] pins_o
);
  logic [1:0] ph_q;
  // pins idle low, encoder at phase 00
  initial begin
    pins_o = '0;
    ph_q = 2'h0;
  end
  // 8 clocks per level, well above the two-flop sampling delay
  task automatic lvl(input int i, input logic v);
    pins_o[i] <= v;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulse(input int i);
    lvl(i, 1'b1);
    lvl(i, 1'b0);
  endtask
  // one encoder edge; forward phases run 00,10,11,01
  task automatic quad(input logic up);
    ph_q = up ? ph_q + 2'h1 : ph_q - 2'h1;
    pins_o[`P_CORE_IN] <= ph_q[1] ^ ph_q[0];
    lvl(`P_CORE_DIR, ph_q[1]);
  endtask
endmodule // sensor_model

// ---- dv/tb.sv ----
// self-checking bench of the timer unit over apb with a pin model.
// assumes gpt_unit, sensor_model and the checker are compiled first.
`timescale 1ns/1ps
`include "gpt_map.vh"
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, vo, co;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd, v;
  logic [31:0] seed = 32'h0000_7487;
  logic pready_o, pslverr_o, err, cmp;
  logic [1:0] tog;
  logic [`NPIN-1:0] pins;
  logic [`NTMR-1:0] tmr_event_o;
  int miscompares = 0, checks_done = 0;
  always #2.5 clk_i = ~clk_i;
  sensor_model u_sens (.clk_i(clk_i), .pins_o(pins));
  gpt_unit u_dut (.*, .core_count_i(pins[0]), .core_dir_i(pins[1]),
    .aux_low_in_i(pins[2]), .aux_low_dir_i(pins[3]),
    .aux_high_in_i(pins[4]), .aux_high_dir_i(pins[5]),
    .fast_core_in_i(pins[6]), .fast_core_dir_i(pins[7]),
    .fast_aux_in_i(pins[8]), .capture_in_i(pins[9]),
    .core_toggle_o(tog[0]), .fast_toggle_o(tog[1]), .compare_clk_o(cmp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      miscompares++;
      final_report();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  // bounded wait for one wrap pulse
  task automatic wait_evt(input int b);
    int n;
    n = 0;
    while (tmr_event_o[b] !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check({31'h0, n < 200}, 32'h0000_0001);
    if (n >= 200) final_report();
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a <= 'h2C; a += 4) rdc(8'(a), 32'h0000_0000);
    // random words read back to their field width, timers stopped
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      co = `OFS_C_CORE + 8'(4 * i);
      wr(co, seed & 32'h0007_fff3);
      rdc(co, seed & 32'h0007_fff3);
      wr(co, 32'h0000_0000);
      wr(8'(4 * i), seed);
      rdc(8'(4 * i), {16'h0000, seed[15:0]});
    end
    // unmapped or misaligned places answer with an error
    wr(8'h30, seed);
    check({31'h0, err}, 32'h0000_0001);
    rdc(8'h06, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    // prescale 0 rate, then a wrap beside the 16-bit edge
    for (int g = 0; g < 2; g++) begin
      vo = g ? `OFS_FCORE : `OFS_CORE;
      co = g ? `OFS_C_FCORE : `OFS_C_CORE;
      wr(vo, 32'h0000_0000);
      wr(co, 32'h0000_0008);
      repeat (400) @(posedge clk_i);
      apb(1'b0, vo, 32'h0000_0000);
      v = 403 >> (2 - g);
      check({31'h0, rd + 2 >= v && rd <= v + 2}, 32'h0000_0001);
      wr(co, 32'h0000_0000);
      wr(vo, g ? 32'h0000_fffd : 32'h0000_0003);
      wr(co, g ? 32'h0000_2008 : 32'h0000_2018);
      wait_evt(g ? `I_FCORE : `I_CORE);
      if (g) check({31'h0, cmp}, 32'h0000_0001);
      // the toggle pin is registered one cycle after the event pulse
      @(posedge clk_i);
      check({31'h0, tog[g]}, 32'h0000_0001);
      wr(co, 32'h0000_0000);
    end
    rdc(`OFS_STATUS, 32'h0000_0069);
    wr(`OFS_STATUS, 32'h0000_001f);
    rdc(`OFS_STATUS, 32'h0000_0060);
    // counter mode on rising pin edges
    wr(`OFS_LOW, 32'h0000_0000);
    wr(`OFS_C_LOW, 32'h0000_020a);
    repeat (5) u_sens.pulse(`P_LOW_IN);
    rdc(`OFS_LOW, 32'h0000_0005);
    // encoder: six edges forward, two back
    wr(`OFS_CORE, 32'h0000_0000);
    wr(`OFS_C_CORE, 32'h0000_000b);
    for (int i = 0; i < 8; i++) u_sens.quad(i < 6);
    rdc(`OFS_CORE, 32'h0000_0004);
    wr(`OFS_C_CORE, 32'h0000_0000);
    // direction pin high turns a running timer downward
    u_sens.lvl(`P_CORE_DIR, 1'b1);
    wr(`OFS_CORE, 32'h0000_0100);
    wr(`OFS_C_CORE, 32'h0000_0028);
    repeat (40) @(posedge clk_i);
    wr(`OFS_C_CORE, 32'h0000_0000);
    u_sens.lvl(`P_CORE_DIR, 1'b0);
    apb(1'b0, `OFS_CORE, 32'h0000_0000);
    check({31'h0, rd < 32'h0000_0100 && rd > 32'h0000_00f0},
          32'h0000_0001);
    // gated: no count while the gate is low
    wr(`OFS_HIGH, 32'h0000_0000);
    wr(`OFS_C_HIGH, 32'h0000_0009);
    repeat (100) @(posedge clk_i);
    rdc(`OFS_HIGH, 32'h0000_0000);
    u_sens.lvl(`P_HIGH_IN, 1'b1);
    repeat (100) @(posedge clk_i);
    u_sens.lvl(`P_HIGH_IN, 1'b0);
    apb(1'b0, `OFS_HIGH, 32'h0000_0000);
    check({31'h0, rd > 20 && rd < 32}, 32'h0000_0001);
    // capture into low aux, reload of core from high aux
    wr(`OFS_CORE, 32'h0000_0abc);
    wr(`OFS_C_LOW, 32'h0000_0205);
    u_sens.pulse(`P_LOW_IN);
    rdc(`OFS_LOW, 32'h0000_0abc);
    wr(`OFS_HIGH, 32'h0000_5555);
    wr(`OFS_C_HIGH, 32'h0000_0204);
    u_sens.pulse(`P_HIGH_IN);
    rdc(`OFS_CORE, 32'h0000_5555);
    // capture register from the capture pin with clear, then core pin
    wr(`OFS_FAUX, 32'h0000_1234);
    wr(`OFS_C_FAUX, 32'h0000_4200);
    u_sens.pulse(`P_CAPTURE_INPUT_PIN);
    rdc(`OFS_CAPTURE_RELOAD_REG, 32'h0000_1234);
    rdc(`OFS_FAUX, 32'h0000_0000);
    wr(`OFS_FAUX, 32'h0000_0777);
    wr(`OFS_C_FAUX, 32'h0001_0200);
    u_sens.pulse(`P_CORE_IN);
    rdc(`OFS_CAPTURE_RELOAD_REG, 32'h0000_0777);
    final_report();
  end
endmodule // tb
